// ===== sar_adc_bus_control.v
// control logic of a 12-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defs.vh"
module sar_adc_bus_control #(
    parameter BIT_CYCLES = `BIT_CYCLES
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // control pins, asynchronous to mclk_i
    input  wire        chip_enable_i,
    input  wire        chip_select_n_i,
    input  wire        read_convert_i,
    input  wire        word_width_sel_i,
    input  wire        byte_address_sel_i,
    // comparator: high when trial sum lies below the input
    input  wire        cmp_below_i,
    // analog side
    output reg  [11:0] dac_trial_o,
    output reg         sampler_hold_o,
    output reg         conv_clk_en_o,
    // status and data bus
    output reg         conversion_busy_flag_o,
    output reg  [11:0] data_o,
    output reg  [11:0] data_oe_o
);
    localparam CW = 16;
    // the comparator reaches the sequencer through two flops, so a bit
    // period under three clocks would judge the trial before last
    localparam MIN_CNT = `SYNC_MIN_CYCLES;
    localparam [CW-1:0] BIT_CNT = (BIT_CYCLES < MIN_CNT) ? MIN_CNT
                                                         : BIT_CYCLES;
    // lane patterns of the three read formats
    localparam [11:0] LANES_OFF  = 12'h000;
    localparam [11:0] LANES_WORD = 12'hFFF;
    localparam [11:0] LANES_HIGH = 12'hFF0;
    localparam [11:0] LANES_LOW  = 12'h0FF;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_BIT  = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    // two-flop synchronisers for the pins
    reg [4:0] pin_meta;
    reg [4:0] pin_sync;
    reg       cmp_meta;
    reg       cmp_sync;
    wire ce  = pin_sync[0];
    wire csn = pin_sync[1];
    wire rc  = pin_sync[2];
    wire w12 = pin_sync[3];
    wire a0  = pin_sync[4];

    reg  [2:0]    state;
    reg  [CW-1:0] tick;
    reg  [3:0]    bit_idx;
    reg  [11:0]   sar;
    reg           short_cyc;
    reg           start_prev;
    reg  [11:0]   result;
    reg  [11:0]   next_oe;
    reg  [11:0]   next_data;
    reg           buf_valid;
    wire          buf_ready;
    wire          out_valid;
    wire [11:0]   out_word;
    wire [11:0]   kept_trial;
    wire          read_req;
    wire [11:0]   want_oe;
    wire [11:0]   want_data;

    function [11:0] one_hot_bit;
        input [3:0] idx;
        begin
            one_hot_bit = 12'h001 << idx;
        end
    endfunction

    // trial word after the comparator verdict on bit idx
    function [11:0] judged;
        input [11:0] trial;
        input [3:0]  idx;
        input        keep;
        begin
            if (keep) begin
                judged = trial;
            end else begin
                judged = trial & ~one_hot_bit(idx);
            end
        end
    endfunction

    // lanes that a read drives, from width select and byte address
    function [11:0] lane_enable;
        input w12_f;
        input a0_f;
        begin
            if (w12_f) begin
                lane_enable = LANES_WORD;
            end else if (!a0_f) begin
                lane_enable = LANES_HIGH;
            end else begin
                lane_enable = LANES_LOW;
            end
        end
    endfunction

    // lane contents; the low byte carries four zero bits above its data
    function [11:0] lane_data;
        input        w12_f;
        input        a0_f;
        input [11:0] word;
        begin
            if (w12_f) begin
                lane_data = word;
            end else if (!a0_f) begin
                lane_data = {word[11:4], 4'h0};
            end else begin
                lane_data = {8'h00, word[3:0]};
            end
        end
    endfunction

    // short cycle: bits 2..0 read zero, bit three reads one
    function [11:0] short_word;
        input [11:0] word;
        begin
            short_word = {word[11:4], 4'h8};
        end
    endfunction

    // start condition formed combinationally from live pins
    wire start_act = ce && !csn && !rc;
    wire start_evt = start_act && !start_prev;
    // a late switch to the short length ends at the next decision
    wire last_bit  = short_cyc ? (bit_idx <= 4'h4)
                               : (bit_idx == 4'h0);

    assign kept_trial = judged(dac_trial_o, bit_idx, cmp_sync);
    assign read_req   = rc && !conversion_busy_flag_o && ce && !csn;
    assign want_oe    = lane_enable(w12, a0);
    assign want_data  = lane_data(w12, a0, result);

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pin_meta <= 5'h02;
            pin_sync <= 5'h02;
        end else begin
            pin_meta <= {byte_address_sel_i, word_width_sel_i,
                         read_convert_i, chip_select_n_i, chip_enable_i};
            pin_sync <= pin_meta;
        end
    end

    // the comparator settles on the analog side, so it is synchronised too
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= cmp_below_i;
            cmp_sync <= cmp_meta;
        end
    end

    // edge detector; its reset level matches the idle start combination,
    // so leaving reset with the pins idle gives no false start
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start_act;
        end
    end

    // conversion sequencer
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state                  <= ST_IDLE;
            tick                   <= 16'h0000;
            bit_idx                <= 4'hB;
            sar                    <= 12'h000;
            short_cyc              <= 1'b0;
            dac_trial_o            <= 12'h000;
            sampler_hold_o         <= 1'b0;
            conv_clk_en_o          <= 1'b0;
            conversion_busy_flag_o <= 1'b0;
            buf_valid              <= 1'b0;
        end else begin
            // a repeated start only refreshes the cycle length
            if (start_evt && state != ST_IDLE) begin
                short_cyc <= a0;
            end
            case (state)
            ST_IDLE: begin
                // the buffer must have room, so a finished word is never lost
                if (start_evt && buf_ready) begin
                    short_cyc              <= a0;
                    sar                    <= 12'h000;
                    dac_trial_o            <= 12'h800;
                    bit_idx                <= 4'hB;
                    tick                   <= 16'h0000;
                    conv_clk_en_o          <= 1'b1;
                    sampler_hold_o         <= 1'b1;
                    conversion_busy_flag_o <= 1'b1;
                    state                  <= ST_BIT;
                end
            end
            ST_BIT: begin
                // one bit per internal period
                if (tick == BIT_CNT - 16'h0001) begin
                    tick <= 16'h0000;
                    sar <= kept_trial;
                    if (last_bit) begin
                        state <= ST_DONE;
                    end else begin
                        bit_idx     <= bit_idx - 4'h1;
                        dac_trial_o <= kept_trial
                                       | one_hot_bit(bit_idx - 4'h1);
                    end
                end else begin
                    tick <= tick + 16'h0001;
                end
            end
            ST_DONE: begin
                buf_valid <= 1'b1;
                if (buf_valid && buf_ready) begin
                    buf_valid              <= 1'b0;
                    conv_clk_en_o          <= 1'b0;
                    sampler_hold_o         <= 1'b0;
                    conversion_busy_flag_o <= 1'b0;
                    state                  <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end

    // undecided low bits of a short result are masked only if short_cyc still holds when the word is pushed
    wire [11:0] fin_word = short_cyc ? short_word(sar) : sar;

    sar_out_buffer #(
        .W (12)
    ) u_buf (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (buf_valid),
        .in_ready_o  (buf_ready),
        .in_data_i   (fin_word),
        .out_valid_o (out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (out_word)
    );

    // output latch holds the last finished result between conversions
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            result <= 12'h000;
        end else if (out_valid) begin
            result <= out_word;
        end
    end

    // three-state control, decoded from live pins every cycle
    always @* begin
        next_oe   = LANES_OFF;
        next_data = result;
        if (read_req) begin
            next_oe   = want_oe;
            next_data = want_data;
        end
        // a finished word still on its way into the latch is not shown yet
        if (conversion_busy_flag_o || state != ST_IDLE || out_valid) begin
            next_oe = LANES_OFF;
        end
    end

    // a byte swap passes through one all-off cycle first
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            data_oe_o <= 12'h000;
            data_o    <= 12'h000;
        end else begin
            data_o <= next_data;
            if (data_oe_o != 12'h000 && next_oe != data_oe_o) begin
                data_oe_o <= 12'h000;
            end else begin
                data_oe_o <= next_oe;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sar_adc_defs.vh
// constants for the successive-approximation converter control block
// Summary of operation
// - conversion starts when the last of the three start inputs becomes active
// - byte address captured at start; high gives 8 bits, low gives 12
// - after 8-bit conversion, low three bits read zero and bit three one; a repeated start with byte address low as it ends leaves all four zero
// - only byte address is captured; other controls act directly
// - busy flag high only while a conversion runs
// - while busy, all result outputs are high impedance
// - start during conversion neither resets nor restarts it
// - repeated start during conversion recaptures byte address, may change length
// - outputs enabled only when read high, idle, enabled and selected
// - word-width select high enables all twelve bits, byte address ignored
// - byte mode, byte address low enables the eight top bits
// - byte mode, address high: top four off, bits 4-7 zero, low four on
// - previous byte disabled before next byte enabled on a switch
// - byte address may change any time without malfunction
// - convert puts sampler in hold; it tracks again when conversion ends
// - start enables internal clock and clears approximation register
// - bits decided msb first; kept when comparator says sum below input
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH
`define CLK_PERIOD_PS     4000
`define BIT_TIME_NS       533
`define BIT_CYCLES        ((`BIT_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RESULT_W          12
`define SHORT_BITS        8
`define BIT_THREE         3
`define SYNC_MIN_CYCLES   3
`endif

// ===== sar_adc_monitor.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_monitor #(
    parameter BIT_CYCLES = 133
) (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    // control pins
    input wire logic        chip_enable_i,
    input wire logic        chip_select_n_i,
    input wire logic        read_convert_i,
    // converter outputs
    input wire logic [11:0] dac_trial_o,
    input wire logic        sampler_hold_o,
    input wire logic        conv_clk_en_o,
    input wire logic        conversion_busy_flag_o,
    input wire logic [11:0] data_o,
    input wire logic [11:0] data_oe_o
);
    // the design never runs a bit period shorter than three clocks
    localparam int CNT       = (BIT_CYCLES < 3) ? 3 : BIT_CYCLES;
    localparam int LONG_LEN  = 12 * CNT + 2;
    localparam int SHORT_LEN = 8 * CNT + 2;
    wire       busy = conversion_busy_flag_o;
    reg [11:0] busy_len;
    // counts busy cycles; a recaptured address may pick either length
    always @(posedge mclk_i) begin
        if (sys_rst_i || !busy)
            busy_len <= 12'h000;
        else
            busy_len <= busy_len + 12'h001;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    a_busy_hiz: assert property (busy |-> data_oe_o == 12'h000)
        else $error("result driven while busy");
    a_start_cause: assert property ($rose(busy) |->
        $past(chip_enable_i, 3) && !$past(chip_select_n_i, 3)
        && !$past(read_convert_i, 3))
        else $error("busy rose without a start");
    a_first_trial: assert property ($rose(busy) |->
        conv_clk_en_o && dac_trial_o == 12'h800)
        else $error("conversion did not begin from msb trial");
    a_hold_busy: assert property (sampler_hold_o == busy)
        else $error("sampler hold differs from busy");
    a_conv_len: assert property ($fell(busy) |->
        busy_len == LONG_LEN[11:0] || busy_len == SHORT_LEN[11:0])
        else $error("conversion length wrong");
    a_read_gate: assert property (data_oe_o != 12'h000 |->
        $past(read_convert_i, 3) && $past(chip_enable_i, 3)
        && !$past(chip_select_n_i, 3))
        else $error("outputs enabled without read");
    a_oe_shape: assert property (data_oe_o inside
        {12'h000, 12'hFFF, 12'hFF0, 12'h0FF})
        else $error("illegal output enable pattern");
    a_byte_gap: assert property (
        (data_oe_o ^ $past(data_oe_o)) != 12'hF0F)
        else $error("bytes switched without a gap");
    a_low_zero: assert property (data_oe_o == 12'h0FF |->
        data_o[7:4] == 4'h0)
        else $error("low byte padding not zero");
    a_result_hold: assert property (
        data_oe_o == 12'hFFF && $past(data_oe_o) == 12'hFFF |->
        $stable(data_o))
        else $error("result changed between conversions");
endmodule
bind sar_adc_bus_control sar_adc_monitor #(.BIT_CYCLES(BIT_CYCLES))
    u_sar_adc_monitor (.mclk_i, .sys_rst_i, .chip_enable_i,
    .chip_select_n_i, .read_convert_i, .dac_trial_o, .sampler_hold_o,
    .conv_clk_en_o, .conversion_busy_flag_o, .data_o, .data_oe_o);
`default_nettype wire

// ===== sar_comparator_model.sv
// comparator facing the trial code, input held as a code
`timescale 1ns/1ps
`default_nettype none
module sar_comparator_model (
    // trial code and held input, 0 to 4096
    input  wire logic [11:0] trial_i,
    input  wire logic [12:0] vin_code_i,
    // decision
    output wire logic        cmp_below_o
);
    // ideal and instant; 13 bits let the input sit above full scale
    assign cmp_below_o = {1'b0, trial_i} < vin_code_i;
endmodule
`default_nettype wire

// ===== sar_out_buffer.v
// two-entry buffer between the conversion engine and the output latch
`timescale 1ns/1ps
`default_nettype none
module sar_out_buffer #(
    parameter W = 12
) (
    // clock and reset
    input  wire         mclk_i,
    input  wire         sys_rst_i,
    // fill side
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    // drain side
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:1];
    reg         wptr;
    reg         rptr;
    reg [1:0]   count;
    wire        push;
    wire        pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rptr];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wptr  <= 1'b0;
            rptr  <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BC = 3;
    logic        mclk_i    = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce        = 1'b0;
    logic        csn       = 1'b1;
    logic        rc        = 1'b1;
    logic        ww        = 1'b1;
    logic        ba        = 1'b0;
    logic [12:0] vin       = 13'h0000;
    wire         cmp;
    wire  [11:0] trial;
    wire         busy;
    wire  [11:0] dat;
    wire  [11:0] oe;
    int          failures  = 0;
    int          tests_run = 0;
    sar_adc_bus_control #(.BIT_CYCLES(BC)) u_sar_adc_bus_control (
        .mclk_i, .sys_rst_i, .chip_enable_i(ce), .chip_select_n_i(csn),
        .read_convert_i(rc), .word_width_sel_i(ww),
        .byte_address_sel_i(ba), .cmp_below_i(cmp), .dac_trial_o(trial),
        .sampler_hold_o(), .conv_clk_en_o(),
        .conversion_busy_flag_o(busy), .data_o(dat), .data_oe_o(oe));
    sar_comparator_model u_sar_comparator_model (
        .trial_i(trial), .vin_code_i(vin), .cmp_below_o(cmp));
    always #2 mclk_i = ~mclk_i;
    task automatic cyc(int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic int sar_model(int v, int nbits);
        int r;
        r = 0;
        for (int b = 11; b > 11 - nbits; b--)
            if ((r | (1 << b)) < v)
                r = r | (1 << b);
        if (nbits == 8)
            r = r | 8;
        return r;
    endfunction
    task automatic wait_busy(logic lvl);
        int k;
        k = 0;
        while (busy !== lvl && k < 100) begin
            cyc(1);
            k++;
        end
        chk("busy", {11'h0, busy}, {11'h0, lvl});
    endtask
    // trig picks the pin that completes the start: ce, csn or rc
    task automatic convert(int trig, logic short_c, logic recap);
        ce = 1'b0;
        csn = 1'b1;
        rc = 1'b1;
        ba = short_c;
        cyc(4);
        ce = (trig != 0);
        csn = (trig == 1);
        rc = (trig == 2);
        cyc(13);
        ce = 1'b1;
        csn = 1'b0;
        rc = 1'b0;
        wait_busy(1'b1);
        if (recap) begin
            ba = 1'b1;
            rc = 1'b1;
            cyc(2);
            chk("oe busy", oe, 12'h000);
            rc = 1'b0;
        end
        wait_busy(1'b0);
    endtask
    task automatic read_all(int e);
        rc = 1'b1;
        ww = 1'b1;
        cyc(6);
        chk("word oe", oe, 12'hFFF);
        chk("word data", dat, e[11:0]);
        ww = 1'b0;
        ba = 1'b0;
        cyc(6);
        chk("msb oe", oe, 12'hFF0);
        chk("msb data", dat & oe, e[11:0] & 12'hFF0);
        ba = 1'b1;
        cyc(6);
        chk("lsb oe", oe, 12'h0FF);
        chk("lsb data", dat & oe, {8'h00, e[3:0]});
        ww = 1'b1;
        cyc(350);
    endtask
    initial begin
        void'($urandom(21));
        cyc(4);
        sys_rst_i = 1'b0;
        cyc(2);
        for (int t = 0; t < 7; t++) begin
            vin = 13'($urandom % 4097);
            convert(t % 3, t[0], t == 6);
            read_all(sar_model(vin, (t[0] || t == 6) ? 8 : 12));
            $display("conversion test %0d done", t);
        end
        ce = 1'b0;
        csn = 1'b0;
        rc = 1'b0;
        cyc(10);
        chk("no start", {11'h0, busy}, 12'h000);
        $display("disabled start test done");
        finish_test();
    end
    initial begin
        #(4 * 20000);
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
